// file: src/tce_cfg.svh
// Notes on behaviour
// - One run bit per channel gates prescaler, counter
// - Run bits reset to one
// - Bits written together start counting together
// - Run bit set plus mode 001 or 010 counts
// - Cleared run bit holds counter value
// - Mode 000 does no counting
// - Mode 000 suppresses input transition requests
// - Mode 001 counts rising source edges
// - Polarity invert counts falling edges instead
// - Mode 010 counts both source edges
// - Pins sampled, filtered, then edge detected
// - External count rate at most half clock
// - Internal clock counts at full rate
// - Count to target then stop clears mode
// - Filter enable sits in channel 0 compare status control, covers all pins
// - Filter passes level after three matching samples
`ifndef TCE_CFG_SVH
`define TCE_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define TCE_RUN_OFF     8'h1e
`define TCE_COMP_OFF    5'h00
`define TCE_CNTR_OFF    5'h0a
`define TCE_CTRL_OFF    5'h0c
`define TCE_COMPARE_STATUS_CONTROL_REG_OFF  5'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TCE_RUN_RST     4'hf
`define TCE_FILT_BIT    13
`define TCE_SRC_CLK     4'h4
`define TCE_SRC_DIV2    4'h5
`define TCE_SRC_DIV4    4'h6
`define TCE_SRC_DIV8    4'h7

`endif

// file: src/tce_input_filter.sv
`timescale 1ns/1ps
`default_nettype none

module tce_input_filter (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // Sample and control
  input  wire logic i_sample,
  input  wire logic i_filt_on,
  // Filtered level
  output logic      o_level
);

  logic [3:0] sh;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh <= 4'h0;
    end else begin
      sh <= {sh[2:0], i_sample};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
    end else if (!i_filt_on) begin
      o_level <= sh[1];
    end else if (sh[3:1] == 3'h0 || sh[3:1] == 3'h7) begin
      o_level <= sh[1];
    end
  end

  filt_agree_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ($past(i_filt_on) && $changed(o_level)) |-> ($past(sh[3:1]) == {3{o_level}}))
    else $error("filter passed level without three agreeing samples");

endmodule // tce_input_filter

`default_nettype wire

// file: src/tce_pkg.sv
package tce_pkg;

  typedef enum logic [2:0] {
    TCE_STOP   = 3'h0,
    TCE_RISE   = 3'h1,
    TCE_BOTH   = 3'h2,
    TCE_GATED  = 3'h3,
    TCE_QUAD   = 3'h4,
    TCE_SIGNED = 3'h5,
    TCE_TRIG   = 3'h6,
    TCE_CASC   = 3'h7
  } tce_mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tce_bus_req_t;

  // Control word: [15:13] mode, [12:9] source, [6] once, [1] invert
  typedef struct packed {
    tce_mode_t  mode;
    logic [3:0] src;
    logic       once;
    logic       input_polarity_invert;
  } tce_ctrl_t;

  typedef logic [3:0][15:0] tce_cnt_arr_t;

endpackage

// file: src/tce_timer_front.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tce_cfg.svh"

module tce_timer_front (
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  // Register port
  input  wire tce_pkg::tce_bus_req_t i_bus,
  output logic [15:0]                o_rd_data,
  // External count pins
  input  wire logic [3:0]            i_pin,
  // Channel state
  output logic [3:0]                 o_run,
  output logic [3:0]                 o_edge_req,
  output tce_pkg::tce_cnt_arr_t      o_count
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // ----------------------------------------
  // Decode and event helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [7:0] a, input logic [1:0] ch,
                                   input logic [4:0] off);
    return a == {1'b0, ch, off};
  endfunction

  function automatic logic src_event(input tce_pkg::tce_ctrl_t c,
                                     input logic [3:0] lvl,
                                     input logic [3:0] prev,
                                     input logic [2:0] psc);
    logic a;
    logic b;
    logic r;
    a = lvl[c.src[1:0]] ^ c.input_polarity_invert;
    b = prev[c.src[1:0]] ^ c.input_polarity_invert;
    r = 1'b0;
    if (!c.src[2]) begin
      // Both-edge mode takes any change, otherwise rising only
      r = (c.mode == tce_pkg::TCE_BOTH) ? (a ^ b) : (a & ~b);
    end else begin
      case (c.src)
        `TCE_SRC_CLK:  r = 1'b1;
        `TCE_SRC_DIV2: r = psc[0];
        `TCE_SRC_DIV4: r = &psc[1:0];
        `TCE_SRC_DIV8: r = &psc;
        default:       r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------
  // Channel run register
  // ----------------------------------------
  logic [3:0] run;
  logic       run_wr;

  assign run_wr = i_bus.wr && (i_bus.addr == `TCE_RUN_OFF);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= `TCE_RUN_RST;
    end else if (run_wr) begin
      run <= i_bus.wdata[3:0];
    end
  end

  assign o_run = run;

  // ----------------------------------------
  // Input filters and edge history
  // ----------------------------------------
  logic [3:0] filt_bit;
  logic [3:0] lvl;
  logic [3:0] prev;

  for (genvar p = 0; p < 4; p++) begin : g_filt
    tce_input_filter u_filt (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (rst_n),
      .i_sample  (i_pin[p]),
      .i_filt_on (filt_bit[0]),
      .o_level   (lvl[p])
    );
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 4'h0;
    end else begin
      prev <= lvl;
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  tce_pkg::tce_ctrl_t ctrl [4];
  logic [15:0]        cnt  [4];
  logic [15:0]        cmp  [4];
  logic [2:0]         psc  [4];
  logic [3:0]         ev;
  logic [3:0]         term;

  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic wr_cnt;
    logic wr_ctrl;
    logic [15:0] cnt_inc;

    assign wr_cnt  = i_bus.wr && reg_hit(i_bus.addr, 2'(c), `TCE_CNTR_OFF);
    assign wr_ctrl = i_bus.wr && reg_hit(i_bus.addr, 2'(c), `TCE_CTRL_OFF);
    assign cnt_inc = cnt[c] + 16'h0001;

    // Only rise and both-edge modes count here
    assign ev[c] = run[c]
                && (ctrl[c].mode == tce_pkg::TCE_RISE
                 || ctrl[c].mode == tce_pkg::TCE_BOTH)
                && src_event(ctrl[c], lvl, prev, psc[c]);
    assign term[c] = ev[c] && ctrl[c].once && (cnt_inc == cmp[c]);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        psc[c] <= 3'h0;
      end else if (run[c]) begin
        psc[c] <= psc[c] + 3'h1;
      end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt[c] <= 16'h0000;
      end else if (wr_cnt) begin
        cnt[c] <= i_bus.wdata;
      end else if (ev[c]) begin
        cnt[c] <= cnt_inc;
      end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl[c] <= '0;
      end else if (wr_ctrl) begin
        ctrl[c].mode <= tce_pkg::tce_mode_t'(i_bus.wdata[15:13]);
        ctrl[c].src  <= i_bus.wdata[12:9];
        ctrl[c].once <= i_bus.wdata[6];
        ctrl[c].input_polarity_invert  <= i_bus.wdata[1];
      end else if (term[c]) begin
        ctrl[c].mode <= tce_pkg::TCE_STOP;
      end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cmp[c]      <= 16'h0000;
        filt_bit[c] <= 1'b0;
      end else if (i_bus.wr) begin
        if (reg_hit(i_bus.addr, 2'(c), `TCE_COMP_OFF)) begin
          cmp[c] <= i_bus.wdata;
        end
        if (reg_hit(i_bus.addr, 2'(c), `TCE_COMPARE_STATUS_CONTROL_REG_OFF)) begin
          filt_bit[c] <= i_bus.wdata[`TCE_FILT_BIT];
        end
      end
    end

    // Transition request on the selected pin
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        o_edge_req[c] <= 1'b0;
      end else begin
        o_edge_req[c] <= (ctrl[c].mode != tce_pkg::TCE_STOP)
                      && !ctrl[c].src[2]
                      && (lvl[ctrl[c].src[1:0]] ^ prev[ctrl[c].src[1:0]]);
      end
    end

    assign o_count[c] = cnt[c];
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    if (i_bus.addr == `TCE_RUN_OFF) begin
      rd_mux = {12'h000, run};
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (reg_hit(i_bus.addr, 2'(c), `TCE_COMP_OFF)) begin
          rd_mux = cmp[c];
        end
        if (reg_hit(i_bus.addr, 2'(c), `TCE_CNTR_OFF)) begin
          rd_mux = cnt[c];
        end
        if (reg_hit(i_bus.addr, 2'(c), `TCE_CTRL_OFF)) begin
          rd_mux = {ctrl[c].mode, ctrl[c].src, 2'h0, ctrl[c].once, 4'h0, ctrl[c].input_polarity_invert, 1'b0};
        end
        if (reg_hit(i_bus.addr, 2'(c), `TCE_COMPARE_STATUS_CONTROL_REG_OFF)) begin
          rd_mux = {2'h0, filt_bit[c], 13'h0000};
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_data <= i_bus.rd ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic cnt0_wr;
  assign cnt0_wr = i_bus.wr && reg_hit(i_bus.addr, 2'h0, `TCE_CNTR_OFF);

  run_reset_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (run == 4'hf))
    else $error("run bits not all set after reset");

  run_start_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    run_wr |=> (run == $past(i_bus.wdata[3:0])))
    else $error("run bits did not take the written value together");

  run_gate_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ev[0] |-> (run[0] && ctrl[0].mode != tce_pkg::TCE_STOP))
    else $error("count event without run bit and mode");

  hold_off_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (!run[0] && !cnt0_wr) |=> (cnt[0] == $past(cnt[0])))
    else $error("counter moved with run bit clear");

  stop_mode_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (ctrl[0].mode == tce_pkg::TCE_STOP && !cnt0_wr) |=> $stable(cnt[0]))
    else $error("counter moved in stop mode");

  edge_gate_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_edge_req[0] |-> ($past(ctrl[0].mode) != tce_pkg::TCE_STOP))
    else $error("transition request in stop mode");

  rise_count_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (run[0] && ctrl[0].mode == tce_pkg::TCE_RISE && !ctrl[0].src[2] && !cnt0_wr
     && (lvl[ctrl[0].src[1:0]] ^ ctrl[0].input_polarity_invert) && !(prev[ctrl[0].src[1:0]] ^ ctrl[0].input_polarity_invert))
    |=> (cnt[0] == $past(cnt[0]) + 16'h0001))
    else $error("rising edge not counted");

  both_edge_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (run[0] && ctrl[0].mode == tce_pkg::TCE_BOTH && !ctrl[0].src[2]
     && (lvl[ctrl[0].src[1:0]] != prev[ctrl[0].src[1:0]])) |-> ev[0])
    else $error("edge missed in both-edge mode");

  full_rate_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (run[0] && ctrl[0].mode == tce_pkg::TCE_RISE && ctrl[0].src == `TCE_SRC_CLK) |-> ev[0])
    else $error("internal clock not counted every cycle");

  once_clear_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (term[0] && !(i_bus.wr && reg_hit(i_bus.addr, 2'h0, `TCE_CTRL_OFF)))
    |=> (ctrl[0].mode == tce_pkg::TCE_STOP))
    else $error("mode not cleared at terminal count");

  rsvd_read_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.rd && i_bus.addr == `TCE_RUN_OFF) |=> (o_rd_data[15:4] == 12'h000))
    else $error("reserved enable bits read nonzero");

  rise_cnt_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    ev[0] && ctrl[0].mode == tce_pkg::TCE_RISE && !ctrl[0].src[2]);
  both_cnt_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    ev[1] && ctrl[1].mode == tce_pkg::TCE_BOTH);
  once_term_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n) term[0]);
  sync_start_c: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
    run_wr && i_bus.wdata[3:0] == 4'hf && run == 4'h0);

endmodule // tce_timer_front

`default_nettype wire

// file: tb/tce_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module tce_pin_model (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // Toggle requests
  input  wire logic [3:0] i_toggle,
  // Pin levels
  output logic [3:0]      o_pin
);
  // Levels move just after an edge and hold a full cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_pin <= 4'h0;
    else o_pin <= o_pin ^ i_toggle;
  end
endmodule // tce_pin_model

`default_nettype wire

// file: tb/test_timer_channel_enable_edge_count.sv
`timescale 1ns/1ps
`default_nettype none

module test_timer_channel_enable_edge_count;
  logic                  i_sys_clk;
  logic                  i_rst_n;
  tce_pkg::tce_bus_req_t i_bus;
  logic [15:0]           o_rd_data;
  logic [3:0]            pin;
  logic [3:0]            tog;
  logic [3:0]            o_run;
  logic [3:0]            o_edge_req;
  tce_pkg::tce_cnt_arr_t o_count;
  int                    errors;
  int                    checks_done;
  int                    cyc;
  int                    req3;
  int                    req0;
  logic [15:0]           snap;
  logic [15:0]           snap1;
  typedef struct {int ch; logic [15:0] ctrl; logic [15:0] exp;} tce_row_t;
  tce_row_t rows[4] = '{'{0, 16'h2000, 16'h0003}, '{1, 16'h2202, 16'h0003},
                        '{2, 16'h4400, 16'h0006}, '{3, 16'h0600, 16'h0000}};

  tce_timer_front DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(i_bus),
    .o_rd_data(o_rd_data), .i_pin(pin), .o_run(o_run), .o_edge_req(o_edge_req),
    .o_count(o_count));
  tce_pin_model u_pins (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_toggle(tog),
    .o_pin(pin));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cyc++;
    if (o_edge_req[3] === 1'b1) req3++;
    if (o_edge_req[0] === 1'b1) req0++;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk) i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_sys_clk) i_bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_sys_clk) i_bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_sys_clk) i_bus <= '0;
    #1 check(o_rd_data, e);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic pulse(input int ch, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_sys_clk) tog[ch] <= 1'b1;
      @(posedge i_sys_clk) tog <= 4'h0;
      repeat (2) @(posedge i_sys_clk);
    end
  endtask

  task automatic done(input string name);
    $display("test %0s done", name);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_bus = '0;
    tog = 4'h0;
    errors = 0;
    checks_done = 0;
    cyc = 0;
    req3 = 0;
    req0 = 0;
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    wait_n(3);
    check({12'h000, o_run}, 16'h000f);
    check(o_count[0], 16'h0000);
    rd(8'h1e, 16'h000f);
    wr(8'h1e, 16'hfff0);
    rd(8'h1e, 16'h0000);
    rd(8'h80, 16'h0000);
    done("reset");
    foreach (rows[r]) begin
      wr(8'h1e, 16'h000f);
      wr(8'(rows[r].ch * 32 + 10), 16'h0000);
      wr(8'(rows[r].ch * 32 + 12), rows[r].ctrl);
      pulse(rows[r].ch, 6);
      wait_n(10);
      check(o_count[rows[r].ch], rows[r].exp);
      done("row");
    end
    check(req3[15:0], 16'h0000);
    check(req0[15:0], 16'h0006);
    wr(8'h1e, 16'h0000);
    wr(8'h0a, 16'h0000);
    wr(8'h2a, 16'h0000);
    wr(8'h0c, 16'h2800);
    wr(8'h2c, 16'h2800);
    wr(8'h1e, 16'h0003);
    wait_n(3);
    check(o_count[0], o_count[1]);
    snap = o_count[0];
    wait_n(10);
    check(o_count[0], snap + 16'h000a);
    wr(8'h1e, 16'h0002);
    wait_n(2);
    snap = o_count[0];
    snap1 = o_count[1];
    wait_n(8);
    check(o_count[0], snap);
    check(o_count[1], snap1 + 16'h0008);
    done("run");
    wr(8'h1e, 16'h000f);
    wr(8'h40, 16'h0003);
    wr(8'h4a, 16'h0000);
    wr(8'h4c, 16'h2840);
    wait_n(20);
    check(o_count[2], 16'h0003);
    rd(8'h4c, 16'h0840);
    done("once");
    wr(8'h0c, 16'h2000);
    wr(8'h0a, 16'h0000);
    wr(8'h14, 16'h2000);
    rd(8'h14, 16'h2000);
    @(posedge i_sys_clk) tog[0] <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    tog <= 4'h0;
    wait_n(12);
    check(o_count[0], 16'h0000);
    pulse(0, 2);
    wait_n(12);
    check(o_count[0], 16'h0001);
    done("filter");
    final_report();
  end
endmodule // test_timer_channel_enable_edge_count

`default_nettype wire
